// [verilog/osp_regs.sv]
// Contract
// - offset low word at 0x00, read-write
// - offset high ten bits at 0x01[9:0]
// - offset word resets to zero
// - offset is signed two's complement
// - high-word write alone applies new offset
// - offset writes accepted any time after reset
// - bit 10 of 0x01 enables drive, default 0
// - pin-controlled mode ignores software enable
// - 0x01[15:11] read zero, ignore writes
// - 0x02[3:0] span select, upper bits read-only
// - master controls span, offset, enable by writes
// - span codes map ascending onto sixteen ranges
// - span has factory default, software overwrites
// - serial slave port up to 1 Mbit/s
`timescale 1ns/10ps
`default_nettype none
module osp_regs #(
    parameter logic [3:0] SPAN_DEFAULT = osp_pkg::OSP_SPAN_FACTORY
) (
    // core clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register access from the serial slave, on the link clock
    input wire logic lk_clk,
    input wire logic lk_wr,
    input wire logic lk_rd,
    input wire logic [7:0] lk_addr,
    input wire logic [15:0] lk_wdata,
    output logic [15:0] lk_rdata,
    output logic lk_rvalid,
    // output-enable pins, asynchronous
    input wire logic oe_pin_mode,
    input wire logic oe_pin,
    // oscillator control, core clock
    output logic signed [25:0] freq_offset_o,
    output logic drive_en_o,
    output logic [3:0] pull_span_o,
    output logic [18:0] pull_span_cppm_o,
    output logic update_o
);
    typedef struct packed {
        logic [15:0] low;
        logic [9:0] high;
        logic oe;
        logic [3:0] span;
        logic [25:0] act;
        logic pend;
        logic [15:0] rdata;
        logic rvalid;
    } osp_lk_t;

    typedef struct packed {
        logic pm_m;
        logic pm_s;
        logic pin_m;
        logic pin_s;
        logic signed [25:0] offset;
        logic sw_oe;
        logic [3:0] span;
        logic [18:0] cppm;
        logic drive;
        logic update;
    } osp_core_t;

    osp_lk_t lk_r, lk_nxt;
    osp_core_t c_r, c_nxt;
    logic lk_rst_m;
    logic lk_rst;
    logic lk_send;
    osp_pkg::osp_snap_t lk_snap;
    osp_pkg::osp_snap_t c_snap;

    osp_sync_if #(.W(osp_pkg::OSP_SNAP_W)) snap_ch ();

    // reset follows sys_rst into the link domain
    always_ff @(posedge lk_clk) begin
        lk_rst_m <= sys_rst;
        lk_rst <= lk_rst_m;
    end

    // link-side register bank
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.rvalid = 1'b0;
        lk_send = 1'b0;
        // hand the latest settings over once the crossing is free
        if (lk_r.pend && !snap_ch.s_busy) begin
            lk_send = 1'b1;
            lk_nxt.pend = 1'b0;
        end
        if (lk_wr) begin
            unique case (lk_addr)
                osp_pkg::OSP_OFS_LOW_ADDR: begin
                    // stored only; the active offset waits for high
                    lk_nxt.low = lk_wdata;
                end
                osp_pkg::OSP_OFS_HIGH_ADDR: begin
                    // bits above the enable are dropped
                    lk_nxt.high = lk_wdata[9:0];
                    lk_nxt.oe = lk_wdata[osp_pkg::OSP_OE_POS];
                    lk_nxt.act = {lk_wdata[9:0], lk_r.low};
                    lk_nxt.pend = 1'b1;
                end
                osp_pkg::OSP_SPAN_ADDR: begin
                    lk_nxt.span = lk_wdata[3:0];
                    lk_nxt.pend = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (lk_rd) begin
            lk_nxt.rvalid = 1'b1;
            unique case (lk_addr)
                osp_pkg::OSP_OFS_LOW_ADDR: begin
                    lk_nxt.rdata = lk_r.low;
                end
                osp_pkg::OSP_OFS_HIGH_ADDR: begin
                    lk_nxt.rdata = {5'h00, lk_r.oe, lk_r.high};
                end
                osp_pkg::OSP_SPAN_ADDR: begin
                    lk_nxt.rdata = {12'h000, lk_r.span};
                end
                default: begin
                    lk_nxt.rdata = osp_pkg::OSP_RD_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge lk_clk) begin
        if (lk_rst) begin
            lk_r.low <= osp_pkg::OSP_LOW_RST;
            lk_r.high <= osp_pkg::OSP_HIGH_RST;
            lk_r.oe <= osp_pkg::OSP_OE_RST;
            lk_r.span <= SPAN_DEFAULT;
            lk_r.act <= '0;
            lk_r.pend <= 1'b0;
            lk_r.rdata <= 16'h0000;
            lk_r.rvalid <= 1'b0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    assign lk_snap = {lk_r.act, lk_r.oe, lk_r.span};
    assign snap_ch.s_send = lk_send;
    assign snap_ch.s_data = lk_snap;

    osp_word_sync #(.W(osp_pkg::OSP_SNAP_W)) u_snap_sync (
        .src_clk(lk_clk),
        .src_rst(lk_rst),
        .dst_clk(clk),
        .dst_rst(sys_rst),
        .ch(snap_ch)
    );

    assign c_snap = snap_ch.d_data;

    // core side: apply settings, pick the drive-enable source
    always_comb begin
        c_nxt = c_r;
        c_nxt.pm_m = oe_pin_mode;
        c_nxt.pm_s = c_r.pm_m;
        c_nxt.pin_m = oe_pin;
        c_nxt.pin_s = c_r.pin_m;
        c_nxt.update = 1'b0;
        if (snap_ch.d_load) begin
            // signed word: negative codes pull below nominal
            c_nxt.offset = signed'(c_snap.offset);
            c_nxt.sw_oe = c_snap.oe;
            c_nxt.span = c_snap.span;
            c_nxt.update = 1'b1;
        end
        c_nxt.cppm = osp_pkg::OSP_SPAN_CPPM[c_nxt.span];
        c_nxt.drive = c_r.pm_s ? c_r.pin_s : c_nxt.sw_oe;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c_r.pm_m <= 1'b0;
            c_r.pm_s <= 1'b0;
            c_r.pin_m <= 1'b0;
            c_r.pin_s <= 1'b0;
            c_r.offset <= '0;
            c_r.sw_oe <= osp_pkg::OSP_OE_RST;
            c_r.span <= SPAN_DEFAULT;
            c_r.cppm <= osp_pkg::OSP_SPAN_CPPM[SPAN_DEFAULT];
            c_r.drive <= 1'b0;
            c_r.update <= 1'b0;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign lk_rdata = lk_r.rdata;
    assign lk_rvalid = lk_r.rvalid;
    assign freq_offset_o = c_r.offset;
    assign drive_en_o = c_r.drive;
    assign pull_span_o = c_r.span;
    assign pull_span_cppm_o = c_r.cppm;
    assign update_o = c_r.update;

    // link-domain checks
    a_low_not_applied: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_OFS_LOW_ADDR |=> $stable(lk_r.act))
        else $error("low-word write changed the active offset");

    a_high_applies_word: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_OFS_HIGH_ADDR
        |=> lk_r.act == {$past(lk_wdata[9:0]), $past(lk_r.low)})
        else $error("high-word write did not form the offset");

    a_high_upper_zero: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_rd && lk_addr == osp_pkg::OSP_OFS_HIGH_ADDR
        |=> lk_rvalid && lk_rdata[15:11] == 5'h00)
        else $error("unused high-word bits read non-zero");

    a_span_upper_zero: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_rd && lk_addr == osp_pkg::OSP_SPAN_ADDR
        |=> lk_rdata[15:4] == 12'h000 && lk_rdata[3:0] == $past(lk_r.span))
        else $error("span register read back wrong");

    a_low_readback: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_OFS_LOW_ADDR && !lk_rd
        ##1 lk_rd && !lk_wr && lk_addr == osp_pkg::OSP_OFS_LOW_ADDR
        |=> lk_rdata == $past(lk_wdata, 2))
        else $error("low word did not read back as written");

    // core-domain checks
    a_reset_defaults: assert property (@(posedge clk)
        sys_rst |=> freq_offset_o == 26'sh0 && !drive_en_o && !update_o)
        else $error("offset or enable not cleared by reset");

    a_pin_mode_drive: assert property (@(posedge clk)
        disable iff (sys_rst)
        c_r.pm_s |=> drive_en_o == $past(c_r.pin_s))
        else $error("pin mode did not follow the enable pin");

    a_soft_drive: assert property (@(posedge clk)
        disable iff (sys_rst)
        !c_r.pm_s && !snap_ch.d_load |=> drive_en_o == $past(c_r.sw_oe))
        else $error("software enable not driven out");

    a_span_table: assert property (@(posedge clk)
        disable iff (sys_rst)
        pull_span_cppm_o == osp_pkg::OSP_SPAN_CPPM[pull_span_o])
        else $error("span range does not match span code");

    a_update_loads: assert property (@(posedge clk)
        disable iff (sys_rst)
        snap_ch.d_load |=> update_o && freq_offset_o == $past(c_snap.offset))
        else $error("crossed offset not applied");

    // link-domain storage and read path
    a_low_stores: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_OFS_LOW_ADDR
        |=> lk_r.low == $past(lk_wdata))
        else $error("low word not stored");

    a_oe_stores: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_OFS_HIGH_ADDR
        |=> lk_r.oe == $past(lk_wdata[osp_pkg::OSP_OE_POS]))
        else $error("enable bit not stored");

    a_span_stores: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_SPAN_ADDR
        |=> lk_r.span == $past(lk_wdata[3:0]))
        else $error("span code not stored");

    a_low_read_data: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_rd && lk_addr == osp_pkg::OSP_OFS_LOW_ADDR
        |=> lk_rdata == $past(lk_r.low))
        else $error("low word read returned wrong data");

    a_high_read_data: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_rd && lk_addr == osp_pkg::OSP_OFS_HIGH_ADDR
        |=> lk_rdata[10:0] == {$past(lk_r.oe), $past(lk_r.high)})
        else $error("high word read returned wrong data");

    a_unmapped_zero: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_rd && lk_addr > osp_pkg::OSP_SPAN_ADDR
        |=> lk_rdata == osp_pkg::OSP_RD_NONE)
        else $error("unmapped address read non-zero");

    a_read_answers: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_rd |=> lk_rvalid)
        else $error("read not answered");

    a_no_stray_valid: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        !lk_rd |=> !lk_rvalid)
        else $error("read valid without a read");

    a_write_pends: assert property (@(posedge lk_clk)
        disable iff (lk_rst)
        lk_wr && (lk_addr == osp_pkg::OSP_OFS_HIGH_ADDR
        || lk_addr == osp_pkg::OSP_SPAN_ADDR) |=> lk_r.pend)
        else $error("setting write not queued for the core");

    a_link_reset: assert property (@(posedge lk_clk)
        lk_rst |=> lk_r.act == '0 && lk_r.low == osp_pkg::OSP_LOW_RST
        && lk_r.high == osp_pkg::OSP_HIGH_RST)
        else $error("offset registers not cleared by reset");

    // core-domain holding and reset
    a_update_pulse: assert property (@(posedge clk)
        disable iff (sys_rst)
        update_o |=> !update_o)
        else $error("update strobe longer than one cycle");

    a_offset_holds: assert property (@(posedge clk)
        disable iff (sys_rst)
        !snap_ch.d_load |=> $stable(freq_offset_o))
        else $error("offset changed without a crossed snapshot");

    a_span_holds: assert property (@(posedge clk)
        disable iff (sys_rst)
        !snap_ch.d_load
        |=> $stable(pull_span_o) && $stable(pull_span_cppm_o))
        else $error("span changed without a crossed snapshot");

    a_span_reset: assert property (@(posedge clk)
        sys_rst |=> pull_span_o == SPAN_DEFAULT
        && pull_span_cppm_o == osp_pkg::OSP_SPAN_CPPM[SPAN_DEFAULT])
        else $error("span not at its factory code after reset");

    a_sw_oe_taken: assert property (@(posedge clk)
        disable iff (sys_rst)
        snap_ch.d_load |=> c_r.sw_oe == $past(c_snap.oe))
        else $error("crossed enable bit not taken");

    c_high_write: cover property (@(posedge lk_clk) disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_OFS_HIGH_ADDR);
    c_span_write: cover property (@(posedge lk_clk) disable iff (lk_rst)
        lk_wr && lk_addr == osp_pkg::OSP_SPAN_ADDR);
    c_core_update: cover property (@(posedge clk) disable iff (sys_rst)
        update_o && freq_offset_o < 0);
    c_pin_mode: cover property (@(posedge clk) disable iff (sys_rst)
        c_r.pm_s && drive_en_o);
    c_wr_then_rd: cover property (@(posedge lk_clk) disable iff (lk_rst)
        lk_wr ##1 lk_rd);
endmodule
`default_nettype wire

// [include/osp_pkg.sv]
package osp_pkg;
    // register addresses on the serial link
    localparam logic [7:0] OSP_OFS_LOW_ADDR = 8'h00;
    localparam logic [7:0] OSP_OFS_HIGH_ADDR = 8'h01;
    localparam logic [7:0] OSP_SPAN_ADDR = 8'h02;
    // field layout
    localparam int OSP_LOW_W = 16;
    localparam int OSP_HIGH_W = 10;
    localparam int OSP_WORD_W = 26;
    localparam int OSP_OE_POS = 10;
    localparam int OSP_SPAN_W = 4;
    localparam int OSP_CPPM_W = 19;
    // values after reset, and the unmapped read value
    localparam logic [15:0] OSP_LOW_RST = 16'h0000;
    localparam logic [9:0] OSP_HIGH_RST = 10'h000;
    localparam logic OSP_OE_RST = 1'b0;
    localparam logic [3:0] OSP_SPAN_FACTORY = 4'h0;
    localparam logic [15:0] OSP_RD_NONE = 16'h0000;
    // timing figures
    localparam int OSP_CLK_HZ = 100_000_000;
    localparam int OSP_LINK_MAX_BPS = 1_000_000;
    localparam int OSP_UPDATE_MAX_HZ = 38_000;
    localparam int OSP_UPDATE_MIN_CYC =
        (OSP_CLK_HZ + OSP_UPDATE_MAX_HZ - 1) / OSP_UPDATE_MAX_HZ;
    // pull span per code, in hundredths of a ppm
    localparam logic [18:0] OSP_SPAN_CPPM [0:15] = '{
        19'h00271, 19'h003e8, 19'h004e2, 19'h009c4,
        19'h01388, 19'h01f40, 19'h02710, 19'h030d4,
        19'h03a98, 19'h04e20, 19'h09c40, 19'h0ea60,
        19'h13880, 19'h1d4c0, 19'h27100, 19'h4e200
    };
    // settings snapshot carried to the core clock
    typedef struct packed {
        logic [25:0] offset;
        logic oe;
        logic [3:0] span;
    } osp_snap_t;
    localparam int OSP_SNAP_W = $bits(osp_snap_t);
endpackage

// [include/osp_sync_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface osp_sync_if #(parameter int W = 8);
    logic s_send;
    logic [W-1:0] s_data;
    logic s_busy;
    logic d_load;
    logic [W-1:0] d_data;
    modport xfer (
        input s_send,
        input s_data,
        output s_busy,
        output d_load,
        output d_data
    );
    modport user (
        output s_send,
        output s_data,
        input s_busy,
        input d_load,
        input d_data
    );
endinterface
`default_nettype wire

// [verilog/osp_word_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module osp_word_sync #(
    parameter int W = 8
) (
    // source domain
    input wire logic src_clk,
    input wire logic src_rst,
    // destination domain
    input wire logic dst_clk,
    input wire logic dst_rst,
    // word channel
    osp_sync_if.xfer ch
);
    if (W < 1) begin : g_chk
        $error("osp_word_sync: W must be at least 1");
    end

    typedef struct packed {
        logic req;
        logic ack_m;
        logic ack_s;
        logic [W-1:0] data;
    } osp_src_t;

    typedef struct packed {
        logic req_m;
        logic req_s;
        logic seen;
        logic load;
        logic [W-1:0] data;
    } osp_dst_t;

    osp_src_t s_r, s_nxt;
    osp_dst_t d_r, d_nxt;

    // source: toggle request, hold word until acknowledged
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack_m = d_r.seen;
        s_nxt.ack_s = s_r.ack_m;
        if (ch.s_send && (s_r.req == s_r.ack_s)) begin
            s_nxt.data = ch.s_data;
            s_nxt.req = ~s_r.req;
        end
    end

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // destination: take the held word once the request arrives
    always_comb begin
        d_nxt = d_r;
        d_nxt.req_m = s_r.req;
        d_nxt.req_s = d_r.req_m;
        d_nxt.load = 1'b0;
        if (d_r.req_s != d_r.seen) begin
            d_nxt.seen = d_r.req_s;
            d_nxt.data = s_r.data;
            d_nxt.load = 1'b1;
        end
    end

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            d_r <= '0;
        end else begin
            d_r <= d_nxt;
        end
    end

    assign ch.s_busy = (s_r.req != s_r.ack_s);
    assign ch.d_load = d_r.load;
    assign ch.d_data = d_r.data;

    a_busy_holds_word: assert property (@(posedge src_clk)
        disable iff (src_rst) ch.s_busy |=> $stable(s_r.data))
        else $error("word changed during crossing");
endmodule
`default_nettype wire

// [test/osp_lk_master.sv]
`timescale 1ns/10ps
`default_nettype none
module osp_lk_master (
    // link clock
    input wire logic lk_clk,
    // word strobes toward the slave
    output logic lk_wr,
    output logic lk_rd,
    output logic [7:0] lk_addr,
    output logic [15:0] lk_wdata
);
    int gap = 0;
    initial begin
        lk_wr = 1'b0;
        lk_rd = 1'b0;
        lk_addr = 8'h00;
        lk_wdata = 16'h0000;
    end
    // one strobe cycle; afterwards address and data turn to junk
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
        repeat (gap) @(posedge lk_clk);
        @(posedge lk_clk);
        lk_wr <= w;
        lk_rd <= ~w;
        lk_addr <= a;
        lk_wdata <= d;
        @(posedge lk_clk);
        lk_wr <= 1'b0;
        lk_rd <= 1'b0;
        lk_addr <= ~a;
        lk_wdata <= ~d;
    endtask
    // write, then read the same address on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
        @(posedge lk_clk);
        lk_wr <= 1'b1;
        lk_addr <= a;
        lk_wdata <= d;
        @(posedge lk_clk);
        lk_wr <= 1'b0;
        lk_rd <= 1'b1;
        @(posedge lk_clk);
        lk_rd <= 1'b0;
        lk_addr <= ~a;
        lk_wdata <= ~d;
    endtask
    // low word first so the high write pairs with it
    task automatic put_ofs(input logic [25:0] o, input logic [5:0] top);
        xfer(1'b1, 8'h00, o[15:0]);
        xfer(1'b1, 8'h01, {top, o[25:16]});
    endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [25:0] ofs;
        logic drv;
        logic [3:0] span;
    } osp_exp_t;
    localparam logic [3:0] SPAN_DEF = 4'h9;
    logic clk = 1'b0;
    logic lk_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic oe_pin_mode = 1'b0;
    logic oe_pin = 1'b0;
    logic lk_wr, lk_rd, lk_rvalid, drive_en_o, update_o, sw_oe;
    logic [7:0] lk_addr;
    logic [15:0] lk_wdata, lk_rdata;
    logic signed [25:0] freq_offset_o;
    logic [3:0] pull_span_o;
    logic [18:0] pull_span_cppm_o;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [31:0] rnd = 32'h0000001c;
    logic [15:0] q_rd[$];
    osp_exp_t q_up[$];
    osp_exp_t cur;

    always #5 clk = ~clk;
    initial #3.3 forever #7.5 lk_clk = ~lk_clk;

    osp_lk_master i_mst (.lk_clk(lk_clk), .lk_wr(lk_wr), .lk_rd(lk_rd),
        .lk_addr(lk_addr), .lk_wdata(lk_wdata));
    osp_regs #(.SPAN_DEFAULT(SPAN_DEF)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .lk_clk(lk_clk), .lk_wr(lk_wr), .lk_rd(lk_rd), .lk_addr(lk_addr),
        .lk_wdata(lk_wdata), .lk_rdata(lk_rdata), .lk_rvalid(lk_rvalid),
        .oe_pin_mode(oe_pin_mode), .oe_pin(oe_pin),
        .freq_offset_o(freq_offset_o), .drive_en_o(drive_en_o),
        .pull_span_o(pull_span_o), .pull_span_cppm_o(pull_span_cppm_o),
        .update_o(update_o));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic bad(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_fail++;
        $display("[ERR] %s exp %h got %h", n, e, g);
    endtask
    task automatic cmp_rd(input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            bad("lk_rdata", 32'(e), 32'(g));
        end
    endtask
    task automatic cmp_up(input osp_exp_t e);
        comparisons++;
        if ({freq_offset_o, drive_en_o, pull_span_o} !== e) begin
            bad("settings", 32'(e), 32'({freq_offset_o, drive_en_o,
                pull_span_o}));
        end
        if (pull_span_cppm_o !== osp_pkg::OSP_SPAN_CPPM[e.span]) begin
            bad("span_cppm", 32'(osp_pkg::OSP_SPAN_CPPM[e.span]),
                32'(pull_span_cppm_o));
        end
    endtask
    task automatic cmp_lvl(input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            bad("drive_en_o", 32'(e), 32'(g));
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        q_rd.push_back(e);
        i_mst.xfer(1'b0, a, 16'h0000);
    endtask
    // push the expected snapshot, write, keep the master's update spacing
    task automatic post(input logic [7:0] a, input logic [15:0] d);
        rnd = lfsr(rnd);
        cur.drv = oe_pin_mode ? oe_pin : sw_oe;
        q_up.push_back(cur);
        if (a == 8'h01) begin
            i_mst.put_ofs(cur.ofs, d[15:10]);
        end else begin
            i_mst.xfer(1'b1, a, d);
        end
        repeat (osp_pkg::OSP_UPDATE_MIN_CYC) @(posedge clk);
    endtask
    task automatic set_ofs(input logic [25:0] o, input logic oe);
        cur.ofs = o;
        sw_oe = oe;
        post(8'h01, {rnd[4:0], oe, 10'h000});
        rd(8'h01, {5'h00, oe, o[25:16]});
        rd(8'h00, o[15:0]);
    endtask
    task automatic set_span(input logic [3:0] c);
        cur.span = c;
        post(8'h02, {rnd[11:0], c});
        rd(8'h02, {12'h000, c});
    endtask

    always @(posedge lk_clk) begin
        if (lk_rvalid === 1'b1) begin
            if (q_rd.size() == 0) begin
                bad("unexpected read", 32'h0, 32'(lk_rdata));
            end else begin
                cmp_rd(q_rd.pop_front(), lk_rdata);
            end
        end
    end
    always @(posedge clk) begin
        if (update_o === 1'b1) begin
            if (q_up.size() == 0) begin
                bad("unexpected update", 32'h0, 32'(freq_offset_o));
            end else begin
                cmp_up(q_up.pop_front());
            end
        end
        cyc++;
        if (cyc == 90000) begin
            bad("cycle limit", 32'h0, 32'(cyc));
            report_and_stop;
        end
    end

    initial begin
        sw_oe = 1'b0;
        cur = {26'h0, 1'b0, SPAN_DEF};
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge lk_clk);
        cmp_up(cur);
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
        rd(8'h02, {12'h000, SPAN_DEF});
        i_mst.xfer(1'b1, 8'h03, 16'hffff);
        rd(8'h03, 16'h0000);
        // low word alone must not move the active offset
        i_mst.xfer(1'b1, 8'h00, 16'h5a5a);
        repeat (50) @(posedge clk);
        rd(8'h00, 16'h5a5a);
        // back-to-back write and read of the low word
        q_rd.push_back(rnd[15:0]);
        i_mst.wr_rd(8'h00, rnd[15:0]);
        i_mst.gap = 3;
        for (int c = 0; c < 16; c++) begin
            set_span(4'(c));
        end
        i_mst.gap = 0;
        set_ofs(26'h2000000, 1'b1);
        set_ofs(26'h1ffffff, 1'b0);
        for (int i = 0; i < 3; i++) begin
            set_ofs(rnd[25:0], rnd[26]);
        end
        @(posedge clk);
        oe_pin_mode <= 1'b1;
        oe_pin <= 1'b1;
        repeat (5) @(posedge clk);
        cmp_lvl(1'b1, drive_en_o);
        set_ofs(rnd[25:0], 1'b0);
        cmp_lvl(1'b1, drive_en_o);
        @(posedge clk);
        oe_pin <= 1'b0;
        repeat (5) @(posedge clk);
        cmp_lvl(1'b0, drive_en_o);
        oe_pin_mode <= 1'b0;
        repeat (5) @(posedge clk);
        set_ofs(rnd[25:0], 1'b1);
        repeat (20) @(posedge lk_clk);
        if (q_rd.size() != 0 || q_up.size() != 0) begin
            bad("missing results", 32'h0, 32'(q_rd.size() + q_up.size()));
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
